/* File: hw/quad_wiper_register_control.sv */
// two-wire slave and register bank for four tap positions
//
// Notes on behaviour
// R1: one 6-bit tap register per pot selects exactly one wiper tap.
// R2: 64 taps per pot; every code selects its own distinct tap.
// R3: four 6-bit saved settings per pot, sixteen in all.
// R4: after power-up each pot loads its first saved setting unasked.
// R5: guard pin low blocks saved-setting writes; tap writes still allowed.
// R6: guard pin high or open allows every read and write.
// R7: transfers start only when address matches the four straps, bit0 LSB.
// R8: data line only pulled low or released, never driven high.
// R9: master supplies serial clock; device times all transfers on it.
// R10: master may read and write every tap and saved register.
// R11: instructions copy tap to saved setting and back, same pot.
// R12: increment/decrement instruction steps tap instead of loading it.
// R13: stepping saturates at lowest and highest codes, no wrap.
`timescale 1ns/1ps
module quad_wiper_register_control import quad_wiper_pkg::*; (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         scl,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire logic                         strap_addr_bit0,
    input  wire logic                         strap_addr_bit1,
    input  wire logic                         strap_addr_bit2,
    input  wire logic                         strap_addr_bit3,
    input  wire logic                         write_guard_n,
    output logic [NUM_POTS*TAP_W-1:0]         tap_position,
    output logic [NUM_POTS*NUM_TAPS-1:0]      wiper_tap_sel,
    output logic                              recall_busy
);
    bus_state_t             state_reg;
    logic [3:0]             bitcnt_reg;
    logic [7:0]             shift_reg;
    logic [1:0]             byte_no_reg;
    logic                   rw_reg;
    logic [3:0]             op_reg;
    logic [POT_W-1:0]       pot_reg;
    logic [SLOT_W-1:0]      slot_reg;
    logic                   rd_saved_reg;
    logic                   sda_oe_reg;
    logic [CNT_W-1:0]       rcnt_reg;
    logic [TAP_W-1:0]       tap_reg [NUM_POTS];

    logic                   scl_s;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   sda_s;
    logic                   sda_rise;
    logic                   sda_fall;
    logic [STRAP_W-1:0]     strap_s;
    logic                   guard_s;
    logic                   start_det;
    logic                   stop_det;
    logic                   byte_done;
    logic                   byte_ack;
    logic                   addr_match;
    logic [3:0]             in_op;
    logic [POT_W-1:0]       in_pot;
    logic [SLOT_W-1:0]      in_slot;
    logic                   tap_we;
    logic [POT_W-1:0]       tap_widx;
    logic [TAP_W-1:0]       tap_wdata;
    logic                   nv_we;
    logic [SAVED_IDX_W-1:0] nv_idx;
    logic [TAP_W-1:0]       nv_wdata;
    logic [TAP_W-1:0]       nv_rdata;
    logic [7:0]             rd_byte;
    logic [1:0]             byte_no_next;

    function automatic logic op_known(input logic [3:0] op);
        op_known = (op == OP_INCDEC)  || (op == OP_RD_TAP)   ||
                   (op == OP_WR_TAP)  || (op == OP_RD_SAVED) ||
                   (op == OP_WR_SAVED)|| (op == OP_RECALL)   ||
                   (op == OP_SAVE);
    endfunction

    function automatic logic [TAP_W-1:0] step_tap(
        input logic [TAP_W-1:0] cur,
        input logic             up
    );
        if (up) begin
            step_tap = (cur == TAP_MAX) ? TAP_MAX : cur + 6'h01; // R13
        end else begin
            step_tap = (cur == TAP_MIN) ? TAP_MIN : cur - 6'h01; // R13
        end
    endfunction

    function automatic logic [NUM_TAPS-1:0] tap_onehot(
        input logic [TAP_W-1:0] code
    );
        tap_onehot       = '0;
        tap_onehot[code] = 1'b1;
    endfunction

    // serial clock is a plain sampled input; all bus timing keys off it
    pin_sync #(.WIDTH(1), .INIT(1'b1)) u_scl_sync ( // R9
        .clk    (clk),
        .resetn (resetn),
        .din    (scl),
        .level  (scl_s),
        .rise   (scl_rise),
        .fall   (scl_fall)
    );

    pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sda_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (sda_in),
        .level  (sda_s),
        .rise   (sda_rise),
        .fall   (sda_fall)
    );

    pin_sync #(.WIDTH(STRAP_W), .INIT(4'h0)) u_strap_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({strap_addr_bit3, strap_addr_bit2,
                  strap_addr_bit1, strap_addr_bit0}),
        .level  (strap_s),
        .rise   (),
        .fall   ()
    );

    // reset value high: an open guard pin counts as writes allowed
    pin_sync #(.WIDTH(1), .INIT(1'b1)) u_guard_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (write_guard_n),
        .level  (guard_s),
        .rise   (),
        .fall   ()
    );

    saved_setting_store u_store ( // R3
        .clk   (clk),
        .we    (nv_we),
        .widx  (nv_idx),
        .wdata (nv_wdata),
        .ridx  (nv_idx),
        .rdata (nv_rdata)
    );

    assign start_det  = scl_s & sda_fall;
    assign stop_det   = scl_s & sda_rise;
    assign byte_done  = (state_reg == ST_RX) & scl_fall &
                        (bitcnt_reg == BITS_BYTE);
    assign in_op      = shift_reg[OP_MSB:OP_LSB];
    assign in_pot     = shift_reg[POT_MSB:POT_LSB];
    assign in_slot    = shift_reg[SLOT_MSB:SLOT_LSB];
    assign addr_match =
        (shift_reg[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEVICE_TYPE) &&
        (shift_reg[ADDR_STRAP_MSB:ADDR_STRAP_LSB] == strap_s); // R7
    assign recall_busy = (rcnt_reg < CNT_W'(NUM_POTS));
    assign byte_no_next = (byte_no_reg == BYTE_DATA) ? BYTE_DATA
                                                     : byte_no_reg + 2'h1;

    // one shared index: recall walk, then the instruction byte, else latched
    always_comb begin
        if (recall_busy) begin
            nv_idx = {rcnt_reg[POT_W-1:0], 2'h0}; // R4
        end else if (byte_no_reg == BYTE_INSTR && !rw_reg) begin
            nv_idx = {in_pot, in_slot};
        end else begin
            nv_idx = {pot_reg, slot_reg};
        end
    end

    // decode of each received byte
    always_comb begin
        byte_ack  = 1'b0;
        tap_we    = 1'b0;
        tap_widx  = pot_reg;
        tap_wdata = shift_reg[TAP_W-1:0];
        nv_we     = 1'b0;
        nv_wdata  = shift_reg[TAP_W-1:0];
        if (byte_done && !recall_busy) begin
            if (byte_no_reg == BYTE_ADDR) begin
                byte_ack = addr_match; // R7
            end else if (byte_no_reg == BYTE_INSTR) begin
                tap_widx = in_pot;
                nv_wdata = tap_reg[in_pot];
                if (in_op == OP_SAVE) begin
                    byte_ack = guard_s; // R5 R6
                    nv_we    = guard_s; // R11
                end else if (in_op == OP_RECALL) begin
                    byte_ack  = 1'b1;
                    tap_we    = 1'b1; // R11
                    tap_wdata = nv_rdata;
                end else begin
                    byte_ack = op_known(in_op);
                end
            end else if (op_reg == OP_WR_TAP) begin
                byte_ack = 1'b1;
                tap_we   = 1'b1; // R10
            end else if (op_reg == OP_WR_SAVED) begin
                byte_ack = guard_s; // R5 R6
                nv_we    = guard_s; // R10
            end else if (op_reg == OP_INCDEC) begin
                byte_ack  = 1'b1;
                tap_we    = 1'b1;
                tap_wdata = step_tap(tap_reg[pot_reg],
                                     shift_reg[STEP_UP_BIT]); // R12
            end
        end
    end

    // read answer: saved word after a read-saved instruction, else tap
    assign rd_byte = rd_saved_reg ? {2'h0, nv_rdata}
                                  : {2'h0, tap_reg[pot_reg]}; // R10

    // power-up recall walk, one pot per cycle after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rcnt_reg <= '0;
        end else if (recall_busy) begin
            rcnt_reg <= rcnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_POTS; i++) begin
                tap_reg[i] <= TAP_RESET;
            end
        end else if (recall_busy) begin
            tap_reg[rcnt_reg[POT_W-1:0]] <= nv_rdata; // R4
        end else if (tap_we) begin
            tap_reg[tap_widx] <= tap_wdata; // R1 R5
        end
    end

    // latched instruction fields
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_reg       <= OP_RD_TAP;
            pot_reg      <= '0;
            slot_reg     <= '0;
            rd_saved_reg <= 1'b0;
        end else if (byte_ack && byte_no_reg == BYTE_INSTR) begin
            op_reg       <= in_op;
            pot_reg      <= in_pot;
            slot_reg     <= in_slot;
            rd_saved_reg <= (in_op == OP_RD_SAVED);
        end
    end

    // bus framing; outputs change only after a falling serial clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= ST_IDLE;
            bitcnt_reg  <= '0;
            shift_reg   <= '0;
            byte_no_reg <= BYTE_ADDR;
            rw_reg      <= 1'b0;
            sda_oe_reg  <= 1'b0;
        end else if (recall_busy || stop_det) begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (start_det) begin
            state_reg   <= ST_RX;
            bitcnt_reg  <= '0;
            byte_no_reg <= BYTE_ADDR;
            rw_reg      <= 1'b0;
            sda_oe_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (scl_rise && bitcnt_reg != BITS_BYTE) begin
                        shift_reg  <= {shift_reg[6:0], sda_s};
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (byte_done) begin
                        // unanswered bytes drop us off the bus till restart
                        state_reg  <= byte_ack ? ST_ACK : ST_IDLE;
                        sda_oe_reg <= byte_ack; // R8
                        if (byte_no_reg == BYTE_ADDR) begin
                            rw_reg <= shift_reg[ADDR_RW_BIT];
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt_reg  <= '0;
                        byte_no_reg <= byte_no_next;
                        if (rw_reg) begin
                            state_reg  <= ST_TX;
                            shift_reg  <= rd_byte;
                            sda_oe_reg <= ~rd_byte[7]; // R8
                        end else begin
                            state_reg  <= ST_RX;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                        if (bitcnt_reg == BIT_LAST) begin
                            state_reg  <= ST_RACK;
                            sda_oe_reg <= 1'b0;
                        end else begin
                            shift_reg  <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg <= ~shift_reg[6]; // R8
                        end
                    end
                end
                ST_RACK: begin
                    // master's low asks for one more byte
                    if (scl_rise) begin
                        state_reg <= sda_s ? ST_IDLE : ST_ACK;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // open drain: the pad level is always low, only the enable moves
    assign sda_out = 1'b0; // R8
    assign sda_oe  = sda_oe_reg;

    generate
        for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
            assign tap_position[p*TAP_W +: TAP_W] = tap_reg[p];
            assign wiper_tap_sel[p*NUM_TAPS +: NUM_TAPS] =
                tap_onehot(tap_reg[p]); // R1 R2
        end
    endgenerate
endmodule // quad_wiper_register_control

/* File: shared/quad_wiper_pkg.sv */
// constants, encodings and states for the quad tap-position controller
package quad_wiper_pkg;
    localparam int TAP_W       = 6;
    localparam int NUM_POTS    = 4;
    localparam int NUM_SLOTS   = 4;
    localparam int NUM_TAPS    = 64;
    localparam int STRAP_W     = 4;
    localparam int POT_W       = 2;
    localparam int SLOT_W      = 2;
    localparam int SAVED_IDX_W = 4;
    localparam int CNT_W       = 3;

    // upper three address bits; value is arbitrary
    localparam logic [2:0] DEVICE_TYPE = 3'h5;

    localparam logic [TAP_W-1:0] TAP_RESET  = 6'h00;
    localparam logic [TAP_W-1:0] TAP_MIN    = 6'h00;
    localparam logic [TAP_W-1:0] TAP_MAX    = 6'h3F;
    localparam logic [TAP_W-1:0] SAVED_INIT = 6'h00;

    // address byte: [7:5] type, [4:1] straps, [0] read
    localparam int ADDR_RW_BIT    = 0;
    localparam int ADDR_STRAP_LSB = 1;
    localparam int ADDR_STRAP_MSB = 4;
    localparam int ADDR_TYPE_LSB  = 5;
    localparam int ADDR_TYPE_MSB  = 7;

    // instruction byte: [7:4] opcode, [3:2] pot, [1:0] slot
    localparam int OP_LSB   = 4;
    localparam int OP_MSB   = 7;
    localparam int POT_LSB  = 2;
    localparam int POT_MSB  = 3;
    localparam int SLOT_LSB = 0;
    localparam int SLOT_MSB = 1;
    localparam int STEP_UP_BIT = 0;

    localparam logic [3:0] OP_INCDEC   = 4'h2;
    localparam logic [3:0] OP_RD_TAP   = 4'h9;
    localparam logic [3:0] OP_WR_TAP   = 4'hA;
    localparam logic [3:0] OP_RD_SAVED = 4'hB;
    localparam logic [3:0] OP_WR_SAVED = 4'hC;
    localparam logic [3:0] OP_RECALL   = 4'hD;
    localparam logic [3:0] OP_SAVE     = 4'hE;

    localparam logic [1:0] BYTE_ADDR  = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA  = 2'h2;

    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } bus_state_t;
endpackage

/* File: hw/pin_sync.sv */
// two-flop synchroniser with edge flags for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] prev_reg;

    // idle-high lines reset high so no false edge shows at release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg  <= INIT;
            level_reg <= INIT;
            prev_reg  <= INIT;
        end else begin
            meta_reg  <= din;
            level_reg <= meta_reg;
            prev_reg  <= level_reg;
        end
    end

    assign level = level_reg;
    assign rise  = level_reg & ~prev_reg;
    assign fall  = ~level_reg & prev_reg;
endmodule // pin_sync

/* File: hw/saved_setting_store.sv */
// saved tap settings: sixteen words, kept across reset
`timescale 1ns/1ps
module saved_setting_store import quad_wiper_pkg::*; #(
    parameter int               DEPTH = NUM_POTS * NUM_SLOTS,
    parameter int               WIDTH = TAP_W,
    parameter logic [WIDTH-1:0] INIT  = SAVED_INIT
) (
    input  wire logic                   clk,
    input  wire logic                   we,
    input  wire logic [SAVED_IDX_W-1:0] widx,
    input  wire logic [WIDTH-1:0]       wdata,
    input  wire logic [SAVED_IDX_W-1:0] ridx,
    output logic      [WIDTH-1:0]       rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // contents stand for the non-volatile state found at power-up
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = INIT;
        end
    end

    // no reset: the words must outlive a reset
    always_ff @(posedge clk) begin
        if (we) begin
            mem[widx] <= wdata;
        end
    end

    assign rdata = mem[ridx];
endmodule // saved_setting_store

/* File: verification/quad_wiper_props.sv */
// concurrent checks on the tap controller ports
`timescale 1ns/1ps
module quad_wiper_props import quad_wiper_pkg::*; (
    input wire logic                         clk,
    input wire logic                         resetn,
    input wire logic                         scl,
    input wire logic                         sda_out,
    input wire logic                         sda_oe,
    input wire logic [NUM_POTS*TAP_W-1:0]    tap_position,
    input wire logic [NUM_POTS*NUM_TAPS-1:0] wiper_tap_sel,
    input wire logic                         recall_busy
);
    logic [3:0] low_cnt;
    logic       decode_ok;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // cycles with serial clock low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 4'h0;
        end else if (scl) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != 4'hF) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end

    always_comb begin
        decode_ok = 1'b1;
        for (int p = 0; p < NUM_POTS; p++) begin
            if (wiper_tap_sel[p*NUM_TAPS +: NUM_TAPS] !=
                (64'h1 << tap_position[p*TAP_W +: TAP_W])) begin
                decode_ok = 1'b0;
            end
        end
    end

    a_drain_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_tap_decode: assert property (decode_ok)
        else $error("wiper select mismatch");
    a_recall_window: assert property ($rose(resetn) |->
        recall_busy [*3] ##[1:3] !recall_busy)
        else $error("recall window length");
    a_recall_quiet: assert property (recall_busy |-> !sda_oe)
        else $error("ack during recall");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("data moved in clock high");
    a_oe_after_fall: assert property ($changed(sda_oe) |->
        low_cnt inside {[2:8]})
        else $error("data not timed from clock fall");
    a_tap_after_fall: assert property (($changed(tap_position) &&
        !recall_busy && !$past(recall_busy)) |-> low_cnt inside {[1:9]})
        else $error("tap not timed from clock fall");
    a_write_acked: assert property (($changed(tap_position) &&
        !recall_busy && !$past(recall_busy)) |-> ##[0:6] sda_oe)
        else $error("tap change not acked");
    a_pull_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("pull too short");

    c_tap_write: cover property ($changed(tap_position) && !recall_busy);
    c_ack: cover property ($rose(sda_oe));
    c_tap_max: cover property (tap_position[TAP_W-1:0] == TAP_MAX);
endmodule // quad_wiper_props

bind quad_wiper_register_control quad_wiper_props props_i (
    .clk(clk), .resetn(resetn), .scl(scl), .sda_out(sda_out),
    .sda_oe(sda_oe), .tap_position(tap_position),
    .wiper_tap_sel(wiper_tap_sel), .recall_busy(recall_busy));

/* File: verification/bus_master_model.sv */
// two-wire bus master: drives serial clock, open-drain data
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic clk,
    input  wire logic sda_oe,
    input  wire logic sda_out,
    output logic      scl,
    output logic      sda_in
);
    logic drive_low;

    // pull-up: a released line reads high
    assign sda_in = !(drive_low || (sda_oe && !sda_out));

    initial begin
        scl = 1'b1;
        drive_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // also serves as repeated start from a low clock
    task automatic start_cond();
        drive_low = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(5);
        drive_low = 1'b1;
        tick(5);
        scl = 1'b0;
        tick(5);
    endtask

    task automatic stop_cond();
        drive_low = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(5);
        drive_low = 1'b0;
        tick(5);
    endtask

    // data moves mid-low, far from both clock edges
    task automatic clock_bit(input logic b, output logic seen);
        drive_low = !b;
        tick(5);
        scl = 1'b1;
        tick(5);
        seen = sda_in;
        tick(5);
        scl = 1'b0;
        tick(5);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
        clock_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(last, s);
    endtask
endmodule // bus_master_model

/* File: verification/testbench.sv */
// self-checking bench for the quad tap controller
`timescale 1ns/1ps
module testbench import quad_wiper_pkg::*;;
    localparam logic [3:0] MY_ADDR = 4'hA;
    logic                         clk;
    logic                         resetn;
    logic                         scl;
    logic                         sda_in;
    logic                         sda_out;
    logic                         sda_oe;
    logic [3:0]                   straps;
    logic                         write_guard_n;
    logic [NUM_POTS*TAP_W-1:0]    tap_position;
    logic [NUM_POTS*NUM_TAPS-1:0] wiper_tap_sel;
    logic                         recall_busy;
    int                           failures = 0;
    int                           total_checks = 0;

    quad_wiper_register_control dut (.clk(clk), .resetn(resetn),
        .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_addr_bit0(straps[0]), .strap_addr_bit1(straps[1]),
        .strap_addr_bit2(straps[2]), .strap_addr_bit3(straps[3]),
        .write_guard_n(write_guard_n), .tap_position(tap_position),
        .wiper_tap_sel(wiper_tap_sel), .recall_busy(recall_busy));
    bus_master_model master (.clk(clk), .sda_oe(sda_oe),
        .sda_out(sda_out), .scl(scl), .sda_in(sda_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        int n;
        resetn = 1'b0;
        master.tick(5);
        resetn = 1'b1;
        for (n = 0; recall_busy !== 1'b0 && n < 20; n++) begin
            master.tick(1);
        end
        if (n == 20) begin
            failures++;
            complete_run();
        end
        master.tick(8);
    endtask

    // data byte always sent; refused ones nack it
    task automatic wr(input logic [3:0] st, input logic [3:0] op,
                      input logic [1:0] pot, input logic [1:0] slot,
                      input logic [7:0] d, output logic [2:0] acks);
        master.start_cond();
        master.put_byte({DEVICE_TYPE, st, 1'h0}, acks[2]);
        master.put_byte({op, pot, slot}, acks[1]);
        master.put_byte(d, acks[0]);
        master.stop_cond();
    endtask

    task automatic rd(input logic [3:0] op, input logic [1:0] pot,
                      input logic [1:0] slot, output logic [7:0] d);
        logic [2:0] a;
        master.start_cond();
        master.put_byte({DEVICE_TYPE, MY_ADDR, 1'h0}, a[2]);
        master.put_byte({op, pot, slot}, a[1]);
        master.start_cond();
        master.put_byte({DEVICE_TYPE, MY_ADDR, 1'h1}, a[0]);
        master.get_byte(1'h1, d);
        master.stop_cond();
        check("read acks", a, 3'h7);
    endtask

    task automatic t_tap_write();
        logic [5:0] vals [4];
        logic [2:0] a;
        logic [7:0] r;
        vals = '{6'h3F, 6'h00, 6'h2A, 6'h15};
        for (int p = 0; p < NUM_POTS; p++) begin
            // upper data bits set: they must be dropped
            wr(MY_ADDR, OP_WR_TAP, 2'(p), 2'h0, {2'h3, vals[p]}, a);
            check("tap ack", a, 3'h7);
            check("tap", tap_position[p*TAP_W +: TAP_W], vals[p]);
            check("select", wiper_tap_sel[p*NUM_TAPS +: NUM_TAPS],
                  64'h1 << vals[p]);
            rd(OP_RD_TAP, 2'(p), 2'h0, r);
            check("tap read", r, {2'h0, vals[p]});
        end
        $display("test tap_write finished");
    endtask

    task automatic t_address();
        logic [2:0] a;
        for (int i = 0; i < 2; i++) begin
            wr(i ? 4'hB : 4'h5, OP_WR_TAP, 2'h0, 2'h0, 8'h07, a);
            check("foreign ack", a, 3'h0);
            check("foreign tap", tap_position[5:0], 6'h3F);
        end
        $display("test address finished");
    endtask

    task automatic t_guard();
        logic [2:0] a;
        logic [7:0] r;
        write_guard_n = 1'b0;
        wr(MY_ADDR, OP_WR_SAVED, 2'h2, 2'h1, 8'h11, a);
        check("guarded save ack", a, 3'h6);
        wr(MY_ADDR, OP_WR_TAP, 2'h2, 2'h0, 8'h22, a);
        check("guarded tap ack", a, 3'h7);
        check("guarded tap", tap_position[17:12], 6'h22);
        wr(MY_ADDR, OP_SAVE, 2'h2, 2'h1, 8'h00, a);
        check("guarded copy ack", a, 3'h4);
        write_guard_n = 1'b1;
        rd(OP_RD_SAVED, 2'h2, 2'h1, r);
        check("refused save", r, 8'h00);
        wr(MY_ADDR, OP_WR_SAVED, 2'h2, 2'h1, 8'h11, a);
        check("open save ack", a, 3'h7);
        rd(OP_RD_SAVED, 2'h2, 2'h1, r);
        check("saved read", r, 8'h11);
        $display("test guard finished");
    endtask

    task automatic t_transfer();
        logic [2:0] a;
        logic [7:0] r;
        wr(MY_ADDR, OP_WR_TAP, 2'h1, 2'h0, 8'h2A, a);
        wr(MY_ADDR, OP_SAVE, 2'h1, 2'h3, 8'h00, a);
        check("save ack", a, 3'h6);
        wr(MY_ADDR, OP_WR_TAP, 2'h1, 2'h0, 8'h05, a);
        wr(MY_ADDR, OP_RECALL, 2'h1, 2'h3, 8'h00, a);
        check("recall ack", a, 3'h6);
        check("recalled tap", tap_position[11:6], 6'h2A);
        rd(OP_RD_SAVED, 2'h1, 2'h3, r);
        check("saved copy", r, 8'h2A);
        $display("test transfer finished");
    endtask

    task automatic t_step();
        logic [2:0] a;
        for (int i = 0; i < 2; i++) begin
            wr(MY_ADDR, OP_WR_TAP, 2'h3, 2'h0, i ? 8'h01 : 8'h3E, a);
            repeat (2) begin
                wr(MY_ADDR, OP_INCDEC, 2'h3, 2'h0, i ? 8'h00 : 8'h01, a);
                check("step ack", a, 3'h7);
                check("step tap", tap_position[23:18],
                      i ? TAP_MIN : TAP_MAX);
            end
        end
        $display("test step finished");
    endtask

    task automatic t_recall();
        logic [2:0] a;
        for (int p = 0; p < NUM_POTS; p++) begin
            wr(MY_ADDR, OP_WR_SAVED, 2'(p), 2'h0, 8'h30 + 8'(p), a);
        end
        do_reset();
        check("recall taps", tap_position,
              {6'h33, 6'h32, 6'h31, 6'h30});
        check("recall select", wiper_tap_sel[63:0], 64'h1 << 6'h30);
        $display("test recall finished");
    endtask

    initial begin
        resetn = 1'b0;
        straps = MY_ADDR;
        write_guard_n = 1'b1;
        do_reset();
        check("power-up taps", tap_position, 24'h000000);
        check("power-up select", wiper_tap_sel[63:0], 64'h1);
        t_tap_write();
        t_address();
        t_guard();
        t_transfer();
        t_step();
        t_recall();
        complete_run();
    end
endmodule // testbench
